// file: rtl/dsp_mem_engine.sv
`timescale 1ns/1ps
`default_nettype none
module dsp_mem_engine #(
  parameter int REFI_STEPS = dsp_pkg::REFI_STEPS
) (
  input wire logic i_lclk,
  input wire logic i_lrst,
  input wire logic i_enable,
  input wire logic i_req_tgl,
  input wire logic i_we,
  input wire logic [dsp_pkg::UADDR_W-1:0] i_addr,
  input wire logic [dsp_pkg::DQ_W-1:0] i_wdata,
  input wire logic [1:0] i_mask,
  input wire logic [dsp_pkg::DQ_W-1:0] i_dq,
  output logic o_ack_tgl,
  output logic [dsp_pkg::DQ_W-1:0] o_rdata,
  output logic o_clk,
  output logic [dsp_pkg::ADDR_W-1:0] o_addr,
  output logic [dsp_pkg::DQ_W-1:0] o_dq,
  output logic o_dq_oe,
  output logic o_mask_hi,
  output logic o_mask_lo,
  output logic o_row_n,
  output logic o_col_n,
  output logic o_write_n,
  output logic o_select_n
);
  import dsp_pkg::*;
  typedef enum logic [8:0] {
    ST_WAIT = 9'h001, ST_PRE = 9'h002, ST_REF1 = 9'h004, ST_REF2 = 9'h008, ST_MODE = 9'h010,
    ST_IDLE = 9'h020, ST_RFSH = 9'h040, ST_ACT = 9'h080, ST_RW = 9'h100
  } dsp_eng_e;
  initial if (REFI_STEPS < 2 || REFI_STEPS >= (1 << CNT_W)) $error("bad refresh interval");
  dsp_eng_e st_r, st_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt, ref_r, ref_nxt;
  logic ph_r, ph_nxt, sel_r, sel_nxt, oe_r, oe_nxt, ack_r, ack_nxt;
  logic [2:0] cmd_r, cmd_nxt;
  logic [1:0] mask_r, mask_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic [DQ_W-1:0] dq_r, dq_nxt, rdata_r, rdata_nxt, dq_s1_r, dq_s2_r;
  logic en_s1_r, en_s2_r, req_s1_r, req_s2_r;
  // pins and crossing words come straight from registers
  assign o_clk = ph_r;
  assign o_row_n = cmd_r[RAS_BIT];
  assign o_col_n = cmd_r[CAS_BIT];
  assign o_write_n = cmd_r[WE_BIT];
  assign o_select_n = sel_r;
  assign o_addr = addr_r;
  assign o_dq = dq_r;
  assign o_dq_oe = oe_r;
  assign o_mask_hi = mask_r[1];
  assign o_mask_lo = mask_r[0];
  assign o_ack_tgl = ack_r;
  assign o_rdata = rdata_r;
  // two-stage synchronisers for the enable level, request toggle and read data pins
  always_ff @(posedge i_lclk)
  begin
    en_s1_r <= i_enable;
    en_s2_r <= en_s1_r;
    req_s1_r <= i_req_tgl;
    req_s2_r <= req_s1_r;
    dq_s1_r <= i_dq;
    dq_s2_r <= dq_s1_r;
  end
  // sequencer: moves only on every second link edge, while the memory clock is high, so commands settle half a memory clock before its rise
  always_comb
  begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    ref_nxt = ref_r;
    cmd_nxt = cmd_r;
    sel_nxt = sel_r;
    addr_nxt = addr_r;
    dq_nxt = dq_r;
    oe_nxt = oe_r;
    mask_nxt = mask_r;
    ack_nxt = ack_r;
    rdata_nxt = rdata_r;
    ph_nxt = ~ph_r;
    if (ph_r)
    begin
      cmd_nxt = CMD_NOP;
      sel_nxt = 1'b1;
      oe_nxt = 1'b0;
      mask_nxt = 2'h0;
      if (cnt_r != '0) cnt_nxt = cnt_r - 1'b1;
      if (ref_r != '0) ref_nxt = ref_r - 1'b1;
      case (st_r)
        ST_WAIT:
          if (!en_s2_r) cnt_nxt = CNT_W'(PWRUP_STEPS - 1);
          else if (cnt_r == '0)
          begin
            cmd_nxt = CMD_PRE;
            sel_nxt = 1'b0;
            addr_nxt = AP_WORD;
            cnt_nxt = CNT_W'(RP_STEPS - 1);
            st_nxt = ST_PRE;
          end
        ST_PRE, ST_REF1:
          if (cnt_r == '0)
          begin
            cmd_nxt = CMD_REF;
            sel_nxt = 1'b0;
            cnt_nxt = CNT_W'(RFC_STEPS - 1);
            st_nxt = (st_r == ST_PRE) ? ST_REF1 : ST_REF2;
          end
        ST_REF2:
          if (cnt_r == '0)
          begin
            cmd_nxt = CMD_MRS;
            sel_nxt = 1'b0;
            addr_nxt = MODE_WORD;
            cnt_nxt = CNT_W'(RP_STEPS - 1);
            st_nxt = ST_MODE;
          end
        ST_MODE, ST_RFSH:
          if (cnt_r == '0)
          begin
            ref_nxt = CNT_W'(REFI_STEPS - 1);
            st_nxt = ST_IDLE;
          end
        ST_IDLE:
          if (ref_r == '0)
          begin
            cmd_nxt = CMD_REF;
            sel_nxt = 1'b0;
            cnt_nxt = CNT_W'(RFC_STEPS - 1);
            st_nxt = ST_RFSH;
          end
          else if (en_s2_r && (req_s2_r != ack_r))
          begin
            cmd_nxt = CMD_ACT;
            sel_nxt = 1'b0;
            addr_nxt = i_addr[UADDR_W-1 -: ROW_W];
            cnt_nxt = CNT_W'(RCD_STEPS - 1);
            st_nxt = ST_ACT;
          end
        ST_ACT:
          if (cnt_r == '0)
          begin
            // auto precharge keeps the bank closed, so every access is a fresh activate
            cmd_nxt = i_we ? CMD_WR : CMD_RD;
            sel_nxt = 1'b0;
            addr_nxt = {{(ADDR_W-COL_W){1'b0}}, i_addr[COL_W-1:0]} | AP_WORD;
            dq_nxt = i_wdata;
            oe_nxt = i_we;
            mask_nxt = i_we ? i_mask : 2'h0;
            cnt_nxt = CNT_W'(i_we ? WRP_STEPS : RD_STEPS - 1);
            st_nxt = ST_RW;
          end
        ST_RW:
          if (cnt_r == '0)
          begin
            if (!i_we) rdata_nxt = dq_s2_r;
            ack_nxt = ~ack_r;
            st_nxt = ST_IDLE;
          end
        default: st_nxt = ST_WAIT;
      endcase
    end
  end
  always_ff @(posedge i_lclk)
  begin
    if (i_lrst)
    begin
      st_r <= ST_WAIT;
      cnt_r <= CNT_W'(PWRUP_STEPS - 1);
      ref_r <= '0;
      ph_r <= 1'b0;
      cmd_r <= CMD_NOP;
      sel_r <= 1'b1;
      addr_r <= '0;
      dq_r <= '0;
      oe_r <= 1'b0;
      mask_r <= 2'h0;
      ack_r <= 1'b0;
      rdata_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      ref_r <= ref_nxt;
      ph_r <= ph_nxt;
      cmd_r <= cmd_nxt;
      sel_r <= sel_nxt;
      addr_r <= addr_nxt;
      dq_r <= dq_nxt;
      oe_r <= oe_nxt;
      mask_r <= mask_nxt;
      ack_r <= ack_nxt;
      rdata_r <= rdata_nxt;
    end
  end
  default clocking cb @(posedge i_lclk); endclocking
  default disable iff (i_lrst);
  // two implications, so pins still unknown before the link reset lands do not trip it
  sel_cmd_a: assert property ((o_select_n |-> cmd_r == CMD_NOP) and (cmd_r == CMD_NOP |-> o_select_n))
    else $error("select and command disagree");
  clk_div_a: assert property (!o_clk |=> o_clk ##1 !o_clk)
    else $error("memory clock not divided by two");
  cmd_hold_a: assert property (o_clk |-> $stable(cmd_r) && $stable(o_addr))
    else $error("command moved at clock rise");
  wr_drive_a: assert property (cmd_r == CMD_WR |-> o_dq_oe) else $error("write without data drive");
  oe_only_wr_a: assert property (o_dq_oe |-> cmd_r == CMD_WR) else $error("data driven outside write");
  // refresh and mode set pull the column strobe low too; only reads and writes are checked for the precharge bit
  col_ap_a: assert property (!o_col_n && o_row_n && !o_select_n |-> o_addr[AP_BIT])
    else $error("column without precharge bit");
  rd_mask_a: assert property (cmd_r == CMD_RD |-> !o_mask_hi && !o_mask_lo)
    else $error("read with mask set");
  wait_quiet_a: assert property (st_r == ST_WAIT |-> o_select_n)
    else $error("command during power-up wait");
  ref_due_a: assert property (st_r == ST_IDLE && ref_r == '0 && ph_r |=> cmd_r == CMD_REF)
    else $error("refresh late");
  act_col_a: assert property (cmd_r == CMD_ACT |-> ##[1:8] (cmd_r == CMD_RD || cmd_r == CMD_WR))
    else $error("no column");
endmodule : dsp_mem_engine
`default_nettype wire

// file: rtl/dsp_pkg.sv
package dsp_pkg;
  // pin widths
  localparam int ADDR_W = 14;
  localparam int DQ_W = 16;
  // client word address = {row, column}
  localparam int ROW_W = 14;
  localparam int COL_W = 9;
  localparam int UADDR_W = ROW_W + COL_W;
  // main port clients
  localparam int CLI_N = 3;
  localparam int CLI_PROC = 0;
  localparam int CLI_VID = 1;
  localparam int CLI_AUD = 2;
  // command code {row strobe, column strobe, write}, active low
  localparam int RAS_BIT = 2;
  localparam int CAS_BIT = 1;
  localparam int WE_BIT = 0;
  localparam logic [2:0] CMD_NOP = 3'h7;
  localparam logic [2:0] CMD_ACT = 3'h3;
  localparam logic [2:0] CMD_RD = 3'h5;
  localparam logic [2:0] CMD_WR = 3'h4;
  localparam logic [2:0] CMD_PRE = 3'h2;
  localparam logic [2:0] CMD_REF = 3'h1;
  localparam logic [2:0] CMD_MRS = 3'h0;
  localparam int AP_BIT = 10;
  localparam logic [13:0] AP_WORD = 14'h0400;
  localparam logic [13:0] MODE_WORD = 14'h0020;
  localparam int CAS_LAT = 2;
  // timing; one step is one period of the memory clock output
  localparam int LINK_NS = 160;
  localparam int STEP_NS = 2 * LINK_NS;
  localparam int T_PWRUP_NS = 100000;
  localparam int T_REFI_NS = 7800;
  localparam int T_RP_NS = 20;
  localparam int T_RFC_NS = 70;
  localparam int T_RCD_NS = 20;
  localparam int T_WRP_NS = 40;
  function automatic int steps_min(input int ns);
    return (ns + STEP_NS - 1) / STEP_NS;
  endfunction : steps_min
  localparam int PWRUP_STEPS = steps_min(T_PWRUP_NS);
  localparam int REFI_STEPS = T_REFI_NS / STEP_NS;
  localparam int RP_STEPS = steps_min(T_RP_NS);
  localparam int RFC_STEPS = steps_min(T_RFC_NS);
  localparam int RCD_STEPS = steps_min(T_RCD_NS);
  localparam int WRP_STEPS = steps_min(T_WRP_NS);
  localparam int RD_STEPS = CAS_LAT + 2;
  localparam int CNT_W = 9;
endpackage : dsp_pkg

// file: rtl/dsp_top.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - two memory ports, fully independent signal sets
// - main port shared by processor and decoders
// - optional second port carries processor traffic only
// - bit zero is MSB on address, data
// - fourteen bit address out, index 13 LSB
// - sixteen bit data, device drives on writes
// - two byte masks, high masks the byte
// - row, column, write strobes form command code
// - second port uses identical command code mapping
// - one active low chip select per port
// - device sources each port's memory clock
module dsp_top (
  input wire logic I_CLK,
  input wire logic I_RESET,
  input wire logic I_MEM_CLK,
  input wire logic I_PRIV_EN,
  input wire logic I_PROC_REQ,
  input wire logic I_PROC_WE,
  input wire logic [dsp_pkg::UADDR_W-1:0] I_PROC_ADDR,
  input wire logic [dsp_pkg::DQ_W-1:0] I_PROC_WDATA,
  input wire logic [1:0] I_PROC_MASK,
  output logic O_PROC_DONE,
  output logic [dsp_pkg::DQ_W-1:0] O_PROC_RDATA,
  input wire logic I_VID_REQ,
  input wire logic I_VID_WE,
  input wire logic [dsp_pkg::UADDR_W-1:0] I_VID_ADDR,
  input wire logic [dsp_pkg::DQ_W-1:0] I_VID_WDATA,
  input wire logic [1:0] I_VID_MASK,
  output logic O_VID_DONE,
  output logic [dsp_pkg::DQ_W-1:0] O_VID_RDATA,
  input wire logic I_AUD_REQ,
  input wire logic I_AUD_WE,
  input wire logic [dsp_pkg::UADDR_W-1:0] I_AUD_ADDR,
  input wire logic [dsp_pkg::DQ_W-1:0] I_AUD_WDATA,
  input wire logic [1:0] I_AUD_MASK,
  output logic O_AUD_DONE,
  output logic [dsp_pkg::DQ_W-1:0] O_AUD_RDATA,
  input wire logic I_PRIV_REQ,
  input wire logic I_PRIV_WE,
  input wire logic [dsp_pkg::UADDR_W-1:0] I_PRIV_ADDR,
  input wire logic [dsp_pkg::DQ_W-1:0] I_PRIV_WDATA,
  input wire logic [1:0] I_PRIV_MASK,
  output logic O_PRIV_DONE,
  output logic [dsp_pkg::DQ_W-1:0] O_PRIV_RDATA,
  output logic [0:dsp_pkg::ADDR_W-1] O_MAIN_MEM_ADDR,
  output logic [0:dsp_pkg::DQ_W-1] O_MAIN_MEM_DQ,
  output logic O_MAIN_MEM_DQ_OE,
  input wire logic [0:dsp_pkg::DQ_W-1] I_MAIN_MEM_DQ,
  output logic O_MAIN_MEM_MASK_HI,
  output logic O_MAIN_MEM_MASK_LO,
  output logic O_MAIN_MEM_ROW_STROBE_N,
  output logic O_MAIN_MEM_COL_STROBE_N,
  output logic O_MAIN_MEM_WRITE_N,
  output logic O_MAIN_MEM_SELECT_N,
  output logic O_MAIN_MEM_CLK_OUT,
  output logic [0:dsp_pkg::ADDR_W-1] O_CPU_MEM_ADDR,
  output logic [0:dsp_pkg::DQ_W-1] O_CPU_MEM_DQ,
  output logic O_CPU_MEM_DQ_OE,
  input wire logic [0:dsp_pkg::DQ_W-1] I_CPU_MEM_DQ,
  output logic O_CPU_MEM_MASK_HI,
  output logic O_CPU_MEM_MASK_LO,
  output logic O_CPU_MEM_ROW_STROBE_N,
  output logic O_CPU_MEM_COL_STROBE_N,
  output logic O_CPU_MEM_WRITE_N,
  output logic O_CPU_MEM_SELECT_N,
  output logic O_CPU_MEM_CLK_OUT
);
  import dsp_pkg::*;
  // round robin: the client after the last winner goes first
  function automatic logic [1:0] rr_pick(input logic [CLI_N-1:0] req, input logic [1:0] last);
    logic [1:0] idx;
    rr_pick = last;
    for (int k = CLI_N; k >= 1; k--)
    begin
      idx = 2'((int'(last) + k) % CLI_N);
      if (req[idx]) rr_pick = idx;
    end
  endfunction : rr_pick
  logic lrst_s1_r, lrst_r;
  logic priv_en_s1_r, priv_en_r;
  logic [CLI_N-1:0] req_v, we_a;
  logic [UADDR_W-1:0] addr_a [CLI_N];
  logic [DQ_W-1:0] wd_a [CLI_N];
  logic [1:0] mask_a [CLI_N];
  logic m_busy_r, m_busy_nxt, m_tgl_r, m_tgl_nxt, m_we_r, m_we_nxt, m_seen_r, m_seen_nxt;
  logic [1:0] m_own_r, m_own_nxt, m_last_r, m_last_nxt, m_mask_r, m_mask_nxt;
  logic [UADDR_W-1:0] m_addr_r, m_addr_nxt;
  logic [DQ_W-1:0] m_wd_r, m_wd_nxt;
  logic [CLI_N-1:0] done_r, done_nxt;
  logic [DQ_W-1:0] rd_r [CLI_N];
  logic [DQ_W-1:0] rd_nxt [CLI_N];
  logic m_ack_s1_r, m_ack_s2_r, m_done, m_ack;
  logic [DQ_W-1:0] m_rdata;
  logic p_busy_r, p_busy_nxt, p_tgl_r, p_tgl_nxt, p_we_r, p_we_nxt, p_seen_r, p_seen_nxt;
  logic p_done_r, p_done_nxt, p_ack_s1_r, p_ack_s2_r, p_done, p_ack;
  logic [1:0] p_mask_r, p_mask_nxt;
  logic [UADDR_W-1:0] p_addr_r, p_addr_nxt;
  logic [DQ_W-1:0] p_wd_r, p_wd_nxt, p_rd_r, p_rd_nxt, p_rdata;
  // a client that was just answered sits out one cycle so its held request is not served twice
  assign req_v = {I_AUD_REQ, I_VID_REQ, I_PROC_REQ} & ~done_r;
  assign we_a = {I_AUD_WE, I_VID_WE, I_PROC_WE};
  assign addr_a[CLI_PROC] = I_PROC_ADDR;
  assign addr_a[CLI_VID] = I_VID_ADDR;
  assign addr_a[CLI_AUD] = I_AUD_ADDR;
  assign wd_a[CLI_PROC] = I_PROC_WDATA;
  assign wd_a[CLI_VID] = I_VID_WDATA;
  assign wd_a[CLI_AUD] = I_AUD_WDATA;
  assign mask_a[CLI_PROC] = I_PROC_MASK;
  assign mask_a[CLI_VID] = I_VID_MASK;
  assign mask_a[CLI_AUD] = I_AUD_MASK;
  assign m_done = m_ack_s2_r != m_seen_r;
  assign p_done = p_ack_s2_r != p_seen_r;
  // answers to clients
  assign O_PROC_DONE = done_r[CLI_PROC];
  assign O_VID_DONE = done_r[CLI_VID];
  assign O_AUD_DONE = done_r[CLI_AUD];
  assign O_PROC_RDATA = rd_r[CLI_PROC];
  assign O_VID_RDATA = rd_r[CLI_VID];
  assign O_AUD_RDATA = rd_r[CLI_AUD];
  assign O_PRIV_DONE = p_done_r;
  assign O_PRIV_RDATA = p_rd_r;
  // link-side reset, acknowledge toggles and the fitted strap, each through two flip-flops
  always_ff @(posedge I_MEM_CLK)
  begin
    lrst_s1_r <= I_RESET;
    lrst_r <= lrst_s1_r;
  end
  always_ff @(posedge I_CLK)
  begin
    m_ack_s1_r <= m_ack;
    m_ack_s2_r <= m_ack_s1_r;
    p_ack_s1_r <= p_ack;
    p_ack_s2_r <= p_ack_s1_r;
    priv_en_s1_r <= I_PRIV_EN;
    priv_en_r <= priv_en_s1_r;
  end
  // main port: one request in flight, its words held still until the acknowledge returns
  always_comb
  begin
    m_busy_nxt = m_busy_r;
    m_tgl_nxt = m_tgl_r;
    m_we_nxt = m_we_r;
    m_seen_nxt = m_seen_r;
    m_own_nxt = m_own_r;
    m_last_nxt = m_last_r;
    m_mask_nxt = m_mask_r;
    m_addr_nxt = m_addr_r;
    m_wd_nxt = m_wd_r;
    done_nxt = '0;
    rd_nxt = rd_r;
    if (m_busy_r && m_done)
    begin
      m_busy_nxt = 1'b0;
      m_seen_nxt = m_ack_s2_r;
      done_nxt[m_own_r] = 1'b1;
      if (!m_we_r) rd_nxt[m_own_r] = m_rdata;
    end
    else if (!m_busy_r && (req_v != '0))
    begin
      m_own_nxt = rr_pick(req_v, m_last_r);
      m_last_nxt = m_own_nxt;
      m_busy_nxt = 1'b1;
      m_tgl_nxt = ~m_tgl_r;
      m_we_nxt = we_a[m_own_nxt];
      m_addr_nxt = addr_a[m_own_nxt];
      m_wd_nxt = wd_a[m_own_nxt];
      m_mask_nxt = mask_a[m_own_nxt];
    end
  end
  always_ff @(posedge I_CLK)
  begin
    if (I_RESET)
    begin
      m_busy_r <= 1'b0;
      m_tgl_r <= 1'b0;
      m_we_r <= 1'b0;
      m_seen_r <= 1'b0;
      m_own_r <= 2'h0;
      m_last_r <= 2'(CLI_N - 1);
      m_mask_r <= 2'h0;
      m_addr_r <= '0;
      m_wd_r <= '0;
      done_r <= '0;
      for (int i = 0; i < CLI_N; i++) rd_r[i] <= '0;
    end
    else
    begin
      m_busy_r <= m_busy_nxt;
      m_tgl_r <= m_tgl_nxt;
      m_we_r <= m_we_nxt;
      m_seen_r <= m_seen_nxt;
      m_own_r <= m_own_nxt;
      m_last_r <= m_last_nxt;
      m_mask_r <= m_mask_nxt;
      m_addr_r <= m_addr_nxt;
      m_wd_r <= m_wd_nxt;
      done_r <= done_nxt;
      rd_r <= rd_nxt;
    end
  end
  // second port: processor only, refused while the port is not fitted
  always_comb
  begin
    p_busy_nxt = p_busy_r;
    p_tgl_nxt = p_tgl_r;
    p_we_nxt = p_we_r;
    p_seen_nxt = p_seen_r;
    p_mask_nxt = p_mask_r;
    p_addr_nxt = p_addr_r;
    p_wd_nxt = p_wd_r;
    p_rd_nxt = p_rd_r;
    p_done_nxt = 1'b0;
    if (p_busy_r && p_done)
    begin
      p_busy_nxt = 1'b0;
      p_seen_nxt = p_ack_s2_r;
      p_done_nxt = 1'b1;
      if (!p_we_r) p_rd_nxt = p_rdata;
    end
    else if (!p_busy_r && priv_en_r && I_PRIV_REQ && !p_done_r)
    begin
      p_busy_nxt = 1'b1;
      p_tgl_nxt = ~p_tgl_r;
      p_we_nxt = I_PRIV_WE;
      p_addr_nxt = I_PRIV_ADDR;
      p_wd_nxt = I_PRIV_WDATA;
      p_mask_nxt = I_PRIV_MASK;
    end
  end
  always_ff @(posedge I_CLK)
  begin
    if (I_RESET)
    begin
      p_busy_r <= 1'b0;
      p_tgl_r <= 1'b0;
      p_we_r <= 1'b0;
      p_seen_r <= 1'b0;
      p_mask_r <= 2'h0;
      p_addr_r <= '0;
      p_wd_r <= '0;
      p_rd_r <= '0;
      p_done_r <= 1'b0;
    end
    else
    begin
      p_busy_r <= p_busy_nxt;
      p_tgl_r <= p_tgl_nxt;
      p_we_r <= p_we_nxt;
      p_seen_r <= p_seen_nxt;
      p_mask_r <= p_mask_nxt;
      p_addr_r <= p_addr_nxt;
      p_wd_r <= p_wd_nxt;
      p_rd_r <= p_rd_nxt;
      p_done_r <= p_done_nxt;
    end
  end
  // two separate engines, nothing shared but the link clock and link reset; vectors [n:0] meet pins [0:n] so MSB lands on bit 0
  dsp_mem_engine u_main (
    .i_lclk(I_MEM_CLK),
    .i_lrst(lrst_r),
    .i_enable(1'b1),
    .i_req_tgl(m_tgl_r),
    .i_we(m_we_r),
    .i_addr(m_addr_r),
    .i_wdata(m_wd_r),
    .i_mask(m_mask_r),
    .i_dq(I_MAIN_MEM_DQ),
    .o_ack_tgl(m_ack),
    .o_rdata(m_rdata),
    .o_clk(O_MAIN_MEM_CLK_OUT),
    .o_addr(O_MAIN_MEM_ADDR),
    .o_dq(O_MAIN_MEM_DQ),
    .o_dq_oe(O_MAIN_MEM_DQ_OE),
    .o_mask_hi(O_MAIN_MEM_MASK_HI),
    .o_mask_lo(O_MAIN_MEM_MASK_LO),
    .o_row_n(O_MAIN_MEM_ROW_STROBE_N),
    .o_col_n(O_MAIN_MEM_COL_STROBE_N),
    .o_write_n(O_MAIN_MEM_WRITE_N),
    .o_select_n(O_MAIN_MEM_SELECT_N)
  );
  // same engine, so the same command code mapping on the second port
  dsp_mem_engine u_cpu (
    .i_lclk(I_MEM_CLK),
    .i_lrst(lrst_r),
    .i_enable(I_PRIV_EN),
    .i_req_tgl(p_tgl_r),
    .i_we(p_we_r),
    .i_addr(p_addr_r),
    .i_wdata(p_wd_r),
    .i_mask(p_mask_r),
    .i_dq(I_CPU_MEM_DQ),
    .o_ack_tgl(p_ack),
    .o_rdata(p_rdata),
    .o_clk(O_CPU_MEM_CLK_OUT),
    .o_addr(O_CPU_MEM_ADDR),
    .o_dq(O_CPU_MEM_DQ),
    .o_dq_oe(O_CPU_MEM_DQ_OE),
    .o_mask_hi(O_CPU_MEM_MASK_HI),
    .o_mask_lo(O_CPU_MEM_MASK_LO),
    .o_row_n(O_CPU_MEM_ROW_STROBE_N),
    .o_col_n(O_CPU_MEM_COL_STROBE_N),
    .o_write_n(O_CPU_MEM_WRITE_N),
    .o_select_n(O_CPU_MEM_SELECT_N)
  );
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RESET);
  one_done_a: assert property ($onehot0(done_r)) else $error("two main clients answered");
  done_owner_a: assert property (m_busy_r && m_done |=> done_r[$past(m_own_r)] && !m_busy_r)
    else $error("answer not sent to owner");
  // last cycle's request vector, indexed by the owner chosen now, not by the previous owner
  grant_req_a: assert property (!m_busy_r && req_v != '0 |=>
    m_busy_r && ($past(req_v) & (3'h1 << m_own_r)) != 3'h0)
    else $error("grant to idle client");
  priv_gate_a: assert property (!p_busy_r && !priv_en_r |=> !p_busy_r)
    else $error("second port took request");
endmodule : dsp_top
`default_nettype wire

// file: sim/dsp_sdram_model.sv
`timescale 1ns/1ps
`default_nettype none
// single-word memory device on one port; commands taken at rising port-clock edges
module dsp_sdram_model (
  input wire logic i_clk,
  input wire logic i_select_n,
  input wire logic i_row_n,
  input wire logic i_col_n,
  input wire logic i_write_n,
  input wire logic [0:13] i_addr,
  input wire logic [0:15] i_dq,
  input wire logic i_mask_hi,
  input wire logic i_mask_lo,
  output logic [0:15] o_dq
);
  import dsp_pkg::*;
  logic [15:0] mem_r [logic [22:0]];
  logic [13:0] row_r = 14'h0000;
  logic [1:0] lat_r = 2'h0;
  logic [15:0] word_r = 16'h0000;
  logic [15:0] old_v;
  logic [2:0] cmd;
  logic [22:0] key;
  assign cmd = {i_row_n, i_col_n, i_write_n};
  assign key = {row_r, i_addr[5:13]};
  initial o_dq = 16'h0000;
  // unselected cycles are ignored; an idle data bus toggles so a stale word never passes
  always @(posedge i_clk)
  begin
    old_v = mem_r.exists(key) ? mem_r[key] : 16'h0000;
    if (!i_select_n && cmd == CMD_ACT)
      row_r <= i_addr;
    if (!i_select_n && cmd == CMD_WR)
      mem_r[key] = {i_mask_hi ? old_v[15:8] : i_dq[0:7], i_mask_lo ? old_v[7:0] : i_dq[8:15]};
    if (!i_select_n && cmd == CMD_RD)
      word_r <= old_v;
    lat_r <= (!i_select_n && cmd == CMD_RD) ? 2'h1 : (lat_r == 2'h0 ? 2'h0 : lat_r + 2'h1);
    o_dq <= (lat_r == 2'h2) ? word_r : ~o_dq;
  end
endmodule : dsp_sdram_model
`default_nettype wire

// file: sim/dsp_top_test.sv
`timescale 1ns/1ps
`default_nettype none
module dsp_top_test;
  import dsp_pkg::*;
  logic I_CLK = 1'b0;
  logic I_MEM_CLK = 1'b0;
  logic I_RESET = 1'b1;
  logic I_PRIV_EN = 1'b0;
  logic req [4] = '{default: 1'b0};
  logic we [4] = '{default: 1'b0};
  logic [UADDR_W-1:0] adr [4] = '{default: '0};
  logic [DQ_W-1:0] wd [4] = '{default: '0};
  logic [1:0] msk [4] = '{default: 2'h0};
  logic done [4];
  logic [DQ_W-1:0] rd [4];
  logic [0:13] m_a, c_a;
  logic [0:15] m_q, c_q, m_mq, c_mq;
  logic m_oe, m_h, m_l, m_r, m_c, m_w, m_s, m_k, c_oe, c_h, c_l, c_r, c_c, c_w, c_s, c_k;
  wire logic [0:15] m_bus = m_oe ? m_q : m_mq;
  wire logic [0:15] c_bus = c_oe ? c_q : c_mq;
  int err_count = 0;
  int samples_checked = 0;
  logic [16:0] exp_q [4][$];
  logic [15:0] shadow [logic [23:0]];
  logic [22:0] a;
  dsp_top uut (.I_CLK(I_CLK), .I_RESET(I_RESET), .I_MEM_CLK(I_MEM_CLK), .I_PRIV_EN(I_PRIV_EN),
    .I_PROC_REQ(req[0]), .I_PROC_WE(we[0]), .I_PROC_ADDR(adr[0]), .I_PROC_WDATA(wd[0]), .I_PROC_MASK(msk[0]),
    .O_PROC_DONE(done[0]), .O_PROC_RDATA(rd[0]),
    .I_VID_REQ(req[1]), .I_VID_WE(we[1]), .I_VID_ADDR(adr[1]), .I_VID_WDATA(wd[1]), .I_VID_MASK(msk[1]),
    .O_VID_DONE(done[1]), .O_VID_RDATA(rd[1]),
    .I_AUD_REQ(req[2]), .I_AUD_WE(we[2]), .I_AUD_ADDR(adr[2]), .I_AUD_WDATA(wd[2]), .I_AUD_MASK(msk[2]),
    .O_AUD_DONE(done[2]), .O_AUD_RDATA(rd[2]),
    .I_PRIV_REQ(req[3]), .I_PRIV_WE(we[3]), .I_PRIV_ADDR(adr[3]), .I_PRIV_WDATA(wd[3]), .I_PRIV_MASK(msk[3]),
    .O_PRIV_DONE(done[3]), .O_PRIV_RDATA(rd[3]),
    .O_MAIN_MEM_ADDR(m_a), .O_MAIN_MEM_DQ(m_q), .O_MAIN_MEM_DQ_OE(m_oe), .I_MAIN_MEM_DQ(m_bus),
    .O_MAIN_MEM_MASK_HI(m_h), .O_MAIN_MEM_MASK_LO(m_l), .O_MAIN_MEM_ROW_STROBE_N(m_r),
    .O_MAIN_MEM_COL_STROBE_N(m_c), .O_MAIN_MEM_WRITE_N(m_w), .O_MAIN_MEM_SELECT_N(m_s), .O_MAIN_MEM_CLK_OUT(m_k),
    .O_CPU_MEM_ADDR(c_a), .O_CPU_MEM_DQ(c_q), .O_CPU_MEM_DQ_OE(c_oe), .I_CPU_MEM_DQ(c_bus),
    .O_CPU_MEM_MASK_HI(c_h), .O_CPU_MEM_MASK_LO(c_l), .O_CPU_MEM_ROW_STROBE_N(c_r),
    .O_CPU_MEM_COL_STROBE_N(c_c), .O_CPU_MEM_WRITE_N(c_w), .O_CPU_MEM_SELECT_N(c_s), .O_CPU_MEM_CLK_OUT(c_k));
  dsp_sdram_model main_mem (.i_clk(m_k), .i_select_n(m_s), .i_row_n(m_r), .i_col_n(m_c), .i_write_n(m_w),
    .i_addr(m_a), .i_dq(m_bus), .i_mask_hi(m_h), .i_mask_lo(m_l), .o_dq(m_mq));
  dsp_sdram_model cpu_mem (.i_clk(c_k), .i_select_n(c_s), .i_row_n(c_r), .i_col_n(c_c), .i_write_n(c_w),
    .i_addr(c_a), .i_dq(c_bus), .i_mask_hi(c_h), .i_mask_lo(c_l), .o_dq(c_mq));
  // link clock offset so its edges never line up with the system clock
  initial forever #12.5 I_CLK = ~I_CLK;
  initial
  begin
    #7;
    forever #80 I_MEM_CLK = ~I_MEM_CLK;
  end
  task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: word %h, wanted %h", $time, got, exp);
    end
  endtask : check_word
  task automatic check_flag(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: flag %b, wanted %b", $time, got, exp);
    end
  endtask : check_flag
  task automatic stop_test;
    if (err_count == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test
  // notes the expected answer, then holds the request until its completion pulse
  task automatic access(input int c, input logic w, input logic [22:0] ad, input logic [15:0] d,
    input logic [1:0] m);
    logic [23:0] k;
    logic [15:0] old;
    int n;
    k = {c == 3, ad};
    old = shadow.exists(k) ? shadow[k] : 16'h0000;
    if (w)
      shadow[k] = {m[1] ? old[15:8] : d[15:8], m[0] ? old[7:0] : d[7:0]};
    exp_q[c].push_back({!w, old});
    @(negedge I_CLK);
    req[c] = 1'b1;
    we[c] = w;
    adr[c] = ad;
    wd[c] = d;
    msk[c] = m;
    n = 0;
    do
    begin
      @(negedge I_CLK);
      n++;
    end
    while (done[c] !== 1'b1 && n < 12000);
    check_flag(done[c], 1'b1);
    req[c] = 1'b0;
  endtask : access
  // any completion pulse must match the oldest pending note of that client
  always @(negedge I_CLK)
    for (int c = 0; c < 4; c++)
      if (done[c] === 1'b1)
      begin
        check_flag(exp_q[c].size() != 0, 1'b1);
        if (exp_q[c].size() != 0 && exp_q[c][0][16])
          check_word(rd[c], exp_q[c][0][15:0]);
        if (exp_q[c].size() != 0)
          void'(exp_q[c].pop_front());
      end
  initial
  begin
    repeat (60000) @(posedge I_CLK);
    err_count++;
    stop_test;
  end
  // main sequence; reset spans four rising link edges so the link copy sees it
  initial
  begin
    void'($urandom(50));
    repeat (24) @(negedge I_CLK);
    I_RESET = 1'b0;
    @(negedge I_CLK);
    req[3] = 1'b1;
    repeat (2000) @(negedge I_CLK);
    req[3] = 1'b0;
    for (int c = 0; c < 3; c++)
    begin
      a = (c == 0) ? 23'h000000 : (c == 1) ? 23'h7FFFFF : 23'($urandom);
      access(c, 1'b1, a, 16'($urandom), 2'b00);
      access(c, 1'b1, a, 16'($urandom), 2'b10);
      access(c, 1'b1, a, 16'($urandom), 2'b01);
      access(c, 1'b0, a, 16'($urandom), 2'b00);
    end
    for (int r = 0; r < 2; r++)
      fork
        access(0, r == 0, 23'h000155, 16'hA5C3, 2'b00);
        access(1, r == 0, 23'h2AAAAA, 16'h3C5A, 2'b00);
        access(2, r == 0, 23'h123456, 16'hF00F, 2'b00);
      join
    I_PRIV_EN = 1'b1;
    access(3, 1'b1, 23'h000155, 16'h1234, 2'b00);
    access(3, 1'b1, 23'h000155, 16'($urandom), 2'b11);
    access(3, 1'b0, 23'h000155, 16'h0000, 2'b00);
    access(0, 1'b0, 23'h000155, 16'h0000, 2'b00);
    stop_test;
  end
endmodule : dsp_top_test
`default_nettype wire
